//--- verilog/pfr_pkg.sv
package pfr_pkg;

	// register byte addresses
	localparam logic [31:0] PFR_ADDR_CTRL   = 32'h0000_0000;
	localparam logic [31:0] PFR_ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] PFR_ADDR_PERIOD = 32'h0000_0008;

	// control fields
	localparam int          PFR_CTRL_FB_BANK_ONE_BIT = 0;
	localparam int          PFR_CTRL_RELOCK_BIT      = 1;
	localparam logic [31:0] PFR_CTRL_RESET           = 32'h0000_0000;

	// status fields
	localparam int PFR_STAT_LOCK_BIT     = 0;
	localparam int PFR_STAT_CFG_B_BIT    = 1;
	localparam int PFR_STAT_BYPASS_BIT   = 2;
	localparam int PFR_STAT_RANGE_OK_BIT = 3;
	localparam int PFR_STAT_FB_MATCH_BIT = 4;
	localparam int PFR_STAT_OUT_ON_BIT   = 5;

	// period field positions
	localparam int PFR_PER_REF_LSB = 0;
	localparam int PFR_PER_FB_LSB  = 16;
	localparam int PFR_PER_W       = 16;

	// oscillator range and model time scale
	localparam int PFR_MCLK_MHZ     = 100;
	localparam int PFR_VCO_FMIN_MHZ = 100;
	localparam int PFR_VCO_FMAX_MHZ = 200;
	localparam int PFR_MODEL_SCALE  = 16;
	localparam int PFR_VCO_PER_MIN_CYC =
		(PFR_MCLK_MHZ * PFR_MODEL_SCALE + PFR_VCO_FMAX_MHZ - 1) / PFR_VCO_FMAX_MHZ;
	localparam int PFR_VCO_PER_MAX_CYC = (PFR_MCLK_MHZ * PFR_MODEL_SCALE) / PFR_VCO_FMIN_MHZ;

	// settling count in reference periods
	localparam int PFR_LOCK_PERIODS = 256;

	// ratio shifts of the oscillator against the reference
	localparam int PFR_SHIFT_CFG_A = 1;
	localparam int PFR_SHIFT_CFG_B = 2;

	typedef enum logic [1:0] {
		PFR_LS_IDLE,
		PFR_LS_SETTLE,
		PFR_LS_LOCKED,
		PFR_LS_BYPASS
	} pfr_loop_state_t;

endpackage : pfr_pkg

//--- verilog/pfr_period_meter.sv
`timescale 1ns/1ns
`default_nettype none

module pfr_period_meter
	import pfr_pkg::*;
#(
	parameter int W = PFR_PER_W
) (
	input  wire logic         i_mclk,
	input  wire logic         i_arst_n,
	input  wire logic         i_sig,
	output var  logic         o_rise,
	output var  logic [W-1:0] o_period,
	output var  logic         o_valid
);

	logic         prev_ff;
	logic         rise_ff;
	logic [W-1:0] cnt_ff;
	logic [W-1:0] period_ff;
	logic         valid_ff;
	logic         nxt_prev;
	logic         nxt_rise;
	logic [W-1:0] nxt_cnt;
	logic [W-1:0] nxt_period;
	logic         nxt_valid;
	logic         rise_now;

	always_comb begin
		rise_now   = i_sig & ~prev_ff;
		nxt_prev   = i_sig;
		nxt_rise   = rise_now;
		nxt_cnt    = (&cnt_ff) ? cnt_ff : cnt_ff + W'(1);
		nxt_period = period_ff;
		nxt_valid  = valid_ff;
		if (rise_now) begin
			nxt_cnt    = W'(1);
			nxt_period = cnt_ff;
			nxt_valid  = ~(&cnt_ff) & (cnt_ff != '0);
		end else if (&cnt_ff) begin
			nxt_valid = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prev_ff   <= 1'b0;
			rise_ff   <= 1'b0;
			cnt_ff    <= '0;
			period_ff <= '0;
			valid_ff  <= 1'b0;
		end else begin
			prev_ff   <= nxt_prev;
			rise_ff   <= nxt_rise;
			cnt_ff    <= nxt_cnt;
			period_ff <= nxt_period;
			valid_ff  <= nxt_valid;
		end
	end

	assign o_rise   = rise_ff;
	assign o_period = period_ff;
	assign o_valid  = valid_ff;

endmodule : pfr_period_meter

`default_nettype wire

//--- verilog/pfr_top.sv
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module pfr_top
	import pfr_pkg::*;
#(
	parameter int LOCK_PERIODS = PFR_LOCK_PERIODS,
	parameter int NOUT         = 3
) (
	input  wire logic            i_mclk,
	input  wire logic            i_arst_n,
	input  wire logic            i_hsel,
	input  wire logic [31:0]     i_haddr,
	input  wire logic [1:0]      i_htrans,
	input  wire logic            i_hwrite,
	input  wire logic [2:0]      i_hsize,
	input  wire logic [31:0]     i_hwdata,
	input  wire logic            i_hready,
	output var  logic [31:0]     o_hrdata,
	output var  logic            o_hreadyout,
	output var  logic            o_hresp,
	input  wire logic            i_reference_clock_in,
	input  wire logic            i_loop_feedback_in,
	input  wire logic            i_ratio_select,
	input  wire logic            i_output_enable_n,
	input  wire logic            i_loop_bypass_test,
	input  wire logic            i_half_rate_divider_clear,
	output var  logic [NOUT-1:0] o_bank_one_clock_outputs,
	output var  logic [NOUT-1:0] o_bank_one_oe_n,
	output var  logic [NOUT-1:0] o_bank_two_clock_outputs,
	output var  logic [NOUT-1:0] o_bank_two_oe_n,
	output var  logic            o_lock
);

	function automatic logic near_equal(input logic [PFR_PER_W-1:0] a,
	                                    input logic [PFR_PER_W-1:0] b);
		logic [PFR_PER_W-1:0] d;
		d = (a > b) ? a - b : b - a;
		return d <= PFR_PER_W'(1);
	endfunction : near_equal

	////////////////////////////////////////////////////////////////////////////
	// edge and period measurement

	logic                 ref_rise;
	logic [PFR_PER_W-1:0] ref_period;
	logic                 ref_valid;
	logic                 fb_rise;
	logic [PFR_PER_W-1:0] fb_period;
	logic                 fb_valid;

	pfr_period_meter #(.W(PFR_PER_W)) u_ref_meter (
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.i_sig    (i_reference_clock_in),
		.o_rise   (ref_rise),
		.o_period (ref_period),
		.o_valid  (ref_valid)
	);

	pfr_period_meter #(.W(PFR_PER_W)) u_fb_meter (
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.i_sig    (i_loop_feedback_in),
		.o_rise   (fb_rise),
		.o_period (fb_period),
		.o_valid  (fb_valid)
	);

	////////////////////////////////////////////////////////////////////////////
	// register bus

	logic        fb_bank_one_ff;
	logic        relock_ff;
	logic        wr_pend_ff;
	logic [31:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic        nxt_fb_bank_one;
	logic        nxt_relock;
	logic        nxt_wr_pend;
	logic [31:0] nxt_wr_addr;
	logic [31:0] nxt_hrdata;
	logic        bus_take;
	logic [31:0] status_word;
	logic [31:0] period_word;
	logic        lock_ff;
	logic        cfg_b;
	logic        range_ok;
	logic        fb_match;

	always_comb begin
		bus_take        = i_hsel & i_hready & i_htrans[1];
		nxt_fb_bank_one = fb_bank_one_ff;
		nxt_relock      = 1'b0;
		nxt_wr_pend     = bus_take & i_hwrite;
		nxt_wr_addr     = bus_take ? i_haddr : wr_addr_ff;
		nxt_hrdata      = 32'h0000_0000;
		status_word     = 32'h0000_0000;
		status_word[PFR_STAT_LOCK_BIT]     = lock_ff;
		status_word[PFR_STAT_CFG_B_BIT]    = cfg_b;
		status_word[PFR_STAT_BYPASS_BIT]   = i_loop_bypass_test;
		status_word[PFR_STAT_RANGE_OK_BIT] = range_ok;
		status_word[PFR_STAT_FB_MATCH_BIT] = fb_match;
		status_word[PFR_STAT_OUT_ON_BIT]   = ~i_output_enable_n;
		period_word = {fb_period, ref_period};
		if (wr_pend_ff && wr_addr_ff == PFR_ADDR_CTRL) begin
			nxt_fb_bank_one = i_hwdata[PFR_CTRL_FB_BANK_ONE_BIT];
			nxt_relock      = i_hwdata[PFR_CTRL_RELOCK_BIT];
		end
		if (bus_take && !i_hwrite) begin
			unique case (i_haddr)
				PFR_ADDR_CTRL: begin
					nxt_hrdata[PFR_CTRL_FB_BANK_ONE_BIT] = nxt_fb_bank_one;
				end
				PFR_ADDR_STATUS: nxt_hrdata = status_word;
				PFR_ADDR_PERIOD: nxt_hrdata = period_word;
				default:         nxt_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fb_bank_one_ff <= PFR_CTRL_RESET[PFR_CTRL_FB_BANK_ONE_BIT];
			relock_ff      <= 1'b0;
			wr_pend_ff     <= 1'b0;
			wr_addr_ff     <= 32'h0000_0000;
			hrdata_ff      <= 32'h0000_0000;
		end else begin
			fb_bank_one_ff <= nxt_fb_bank_one;
			relock_ff      <= nxt_relock;
			wr_pend_ff     <= nxt_wr_pend;
			wr_addr_ff     <= nxt_wr_addr;
			hrdata_ff      <= nxt_hrdata;
		end
	end

	assign o_hrdata    = hrdata_ff;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// ratio choice and oscillator range

	logic [PFR_PER_W-1:0] vco_half;

	always_comb begin
		cfg_b    = i_ratio_select & fb_bank_one_ff;
		vco_half = cfg_b ? (ref_period >> PFR_SHIFT_CFG_B)
		                 : (ref_period >> PFR_SHIFT_CFG_A);
		range_ok = ref_valid
		         && vco_half >= PFR_PER_W'(PFR_VCO_PER_MIN_CYC)
		         && vco_half <= PFR_PER_W'(PFR_VCO_PER_MAX_CYC);
		fb_match = fb_valid & ref_valid & near_equal(fb_period, ref_period);
	end

	////////////////////////////////////////////////////////////////////////////
	// oscillator dividers and bypass divider

	logic                 vco2_ff;
	logic                 vco4_ff;
	logic                 byp_div_ff;
	logic [PFR_PER_W-1:0] tick_ff;
	logic                 clr_prev_ff;
	logic                 nxt_vco2;
	logic                 nxt_vco4;
	logic                 nxt_byp_div;
	logic [PFR_PER_W-1:0] nxt_tick;
	logic                 clr_fall;

	always_comb begin
		clr_fall    = clr_prev_ff & ~i_half_rate_divider_clear;
		nxt_vco2    = vco2_ff;
		nxt_vco4    = vco4_ff;
		nxt_byp_div = byp_div_ff;
		nxt_tick    = tick_ff + PFR_PER_W'(1);
		if (!ref_valid || vco_half == '0) begin
			nxt_vco2 = 1'b0;
			nxt_vco4 = 1'b0;
			nxt_tick = '0;
		end else if (ref_rise) begin
			// align a rising oscillator edge with the reference edge
			nxt_tick = PFR_PER_W'(1);
			nxt_vco2 = 1'b1;
			nxt_vco4 = cfg_b ? 1'b1 : ~vco4_ff;
		end else if (tick_ff >= vco_half) begin
			nxt_tick = PFR_PER_W'(1);
			nxt_vco2 = ~vco2_ff;
			if (!vco2_ff) begin
				nxt_vco4 = ~vco4_ff;
			end
		end
		if (ref_rise) begin
			nxt_byp_div = ~byp_div_ff;
		end
		if (clr_fall) begin
			nxt_vco4    = 1'b0;
			nxt_byp_div = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			vco2_ff     <= 1'b0;
			vco4_ff     <= 1'b0;
			byp_div_ff  <= 1'b0;
			tick_ff     <= '0;
			clr_prev_ff <= 1'b0;
		end else begin
			vco2_ff     <= nxt_vco2;
			vco4_ff     <= nxt_vco4;
			byp_div_ff  <= nxt_byp_div;
			tick_ff     <= nxt_tick;
			clr_prev_ff <= i_half_rate_divider_clear;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lock tracking

	pfr_loop_state_t      state_ff;
	pfr_loop_state_t      nxt_state;
	logic [15:0]          settle_ff;
	logic [15:0]          nxt_settle;
	logic                 nxt_lock;
	logic                 sel_prev_ff;
	logic                 oe_prev_ff;
	logic [PFR_PER_W-1:0] per_prev_ff;
	logic                 disturb;

	always_comb begin
		disturb = (i_ratio_select != sel_prev_ff)
		        | (oe_prev_ff & ~i_output_enable_n)
		        | relock_ff
		        | (ref_rise & ~near_equal(ref_period, per_prev_ff));
		nxt_state  = state_ff;
		nxt_settle = settle_ff;
		unique case (state_ff)
			PFR_LS_IDLE: begin
				nxt_settle = '0;
				if (ref_valid) begin
					nxt_state = PFR_LS_SETTLE;
				end
			end
			PFR_LS_SETTLE: begin
				if (disturb || !range_ok || i_output_enable_n) begin
					nxt_settle = '0;
				end else if (ref_rise && fb_match) begin
					nxt_settle = settle_ff + 16'h0001;
					if (settle_ff >= 16'(LOCK_PERIODS - 1)) begin
						nxt_state = PFR_LS_LOCKED;
					end
				end
			end
			PFR_LS_LOCKED: begin
				if (disturb || !range_ok || !fb_match || i_output_enable_n) begin
					nxt_state  = PFR_LS_SETTLE;
					nxt_settle = '0;
				end
			end
			PFR_LS_BYPASS: begin
				nxt_settle = '0;
				if (!i_loop_bypass_test) begin
					nxt_state = PFR_LS_SETTLE;
				end
			end
		endcase
		if (i_loop_bypass_test) begin
			nxt_state = PFR_LS_BYPASS;
		end else if (!ref_valid) begin
			nxt_state = PFR_LS_IDLE;
		end
		nxt_lock = (nxt_state == PFR_LS_LOCKED);
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff    <= PFR_LS_IDLE;
			settle_ff   <= '0;
			lock_ff     <= 1'b0;
			sel_prev_ff <= 1'b0;
			oe_prev_ff  <= 1'b1;
			per_prev_ff <= '0;
		end else begin
			state_ff    <= nxt_state;
			settle_ff   <= nxt_settle;
			lock_ff     <= nxt_lock;
			sel_prev_ff <= i_ratio_select;
			oe_prev_ff  <= i_output_enable_n;
			per_prev_ff <= ref_rise ? ref_period : per_prev_ff;
		end
	end

	assign o_lock = lock_ff;

	////////////////////////////////////////////////////////////////////////////
	// output banks

	logic [NOUT-1:0] b1_ff;
	logic [NOUT-1:0] b2_ff;
	logic [NOUT-1:0] b1_oe_n_ff;
	logic [NOUT-1:0] b2_oe_n_ff;
	logic            nxt_b1;
	logic            nxt_b2;

	always_comb begin
		if (i_loop_bypass_test) begin
			nxt_b2 = i_reference_clock_in;
			nxt_b1 = i_ratio_select ? byp_div_ff : i_reference_clock_in;
		end else begin
			nxt_b2 = vco2_ff;
			nxt_b1 = i_ratio_select ? vco4_ff : vco2_ff;
		end
		if (i_output_enable_n) begin
			nxt_b1 = 1'b0;
			nxt_b2 = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			b1_ff      <= '0;
			b2_ff      <= '0;
			b1_oe_n_ff <= '1;
			b2_oe_n_ff <= '1;
		end else begin
			b1_ff      <= {NOUT{nxt_b1}};
			b2_ff      <= {NOUT{nxt_b2}};
			b1_oe_n_ff <= {NOUT{i_output_enable_n}};
			b2_oe_n_ff <= {NOUT{i_output_enable_n}};
		end
	end

	assign o_bank_one_clock_outputs = b1_ff;
	assign o_bank_two_clock_outputs = b2_ff;
	assign o_bank_one_oe_n          = b1_oe_n_ff;
	assign o_bank_two_oe_n          = b2_oe_n_ff;

endmodule : pfr_top

`default_nettype wire

//--- verification/pfr_top_sva.sv
`timescale 1ns/1ns
`default_nettype none

module pfr_top_sva
	import pfr_pkg::*;
#(
	parameter int NOUT = 3
) (
	input wire logic            i_mclk,
	input wire logic            i_arst_n,
	input wire logic            i_ratio_select,
	input wire logic            i_output_enable_n,
	input wire logic            i_loop_bypass_test,
	input wire logic            i_half_rate_divider_clear,
	input wire logic [NOUT-1:0] o_bank_one_clock_outputs,
	input wire logic [NOUT-1:0] o_bank_one_oe_n,
	input wire logic [NOUT-1:0] o_bank_two_clock_outputs,
	input wire logic [NOUT-1:0] o_bank_two_oe_n,
	input wire logic            o_lock
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	////////////////////////////////////////////////////////////////
	// run lengths of bank two
	logic [7:0] cnt_ff;
	logic [7:0] lo_ff;
	logic       b_ff;
	wire  logic b2 = o_bank_two_clock_outputs[0];
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_ff <= 8'h00;
			lo_ff  <= 8'h00;
			b_ff   <= 1'b0;
		end else begin
			b_ff <= b2;
			if (b2 != b_ff) cnt_ff <= 8'h01;
			else if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
			if (b2 != b_ff && !b_ff) lo_ff <= cnt_ff;
		end
	end
	////////////////////////////////////////////////////////////////
	a_oe_float: assert property (i_output_enable_n |=>
		o_bank_one_oe_n == '1 && o_bank_two_oe_n == '1) else $error("outputs not floated");
	a_oe_drive: assert property (!i_output_enable_n |=>
		o_bank_one_oe_n == '0 && o_bank_two_oe_n == '0) else $error("outputs not driven");
	a_off_quiet: assert property (i_output_enable_n [*3] |->
		o_bank_one_clock_outputs == '0 && o_bank_two_clock_outputs == '0)
		else $error("disabled outputs not low");
	a_bank_one_same: assert property (o_bank_one_clock_outputs == '0 ||
		o_bank_one_clock_outputs == '1) else $error("bank one bits differ");
	a_bank_two_same: assert property (o_bank_two_clock_outputs == '0 ||
		o_bank_two_clock_outputs == '1) else $error("bank two bits differ");
	a_bypass_no_lock: assert property (i_loop_bypass_test [*3] |-> !o_lock)
		else $error("lock shown in bypass");
	a_duty_even: assert property (o_lock && b_ff && !b2 && lo_ff != 8'h00 &&
		lo_ff < 8'h30 |-> cnt_ff <= lo_ff + 8'h01 && lo_ff <= cnt_ff + 8'h01)
		else $error("bank two duty uneven");
	a_clear_div: assert property ($fell(i_half_rate_divider_clear) && i_ratio_select &&
		!i_output_enable_n |-> ##[1:3] o_bank_one_clock_outputs == '0)
		else $error("clear did not reset divider");
endmodule : pfr_top_sva

bind pfr_top pfr_top_sva #(.NOUT(NOUT)) u_sva (.i_mclk, .i_arst_n, .i_ratio_select,
	.i_output_enable_n, .i_loop_bypass_test, .i_half_rate_divider_clear,
	.o_bank_one_clock_outputs, .o_bank_one_oe_n, .o_bank_two_clock_outputs,
	.o_bank_two_oe_n, .o_lock);

`default_nettype wire

//--- verification/pfr_board.sv
`timescale 1ns/1ns
`default_nettype none

module pfr_board (
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_period,
	input  wire logic [7:0] i_high,
	input  wire logic       i_fb_bank_one,
	input  wire logic [2:0] i_b1,
	input  wire logic [2:0] i_oe1_n,
	input  wire logic [2:0] i_b2,
	input  wire logic [2:0] i_oe2_n,
	output var  logic       o_ref,
	output var  logic       o_fb
);
	logic flip_ff = 1'b0;
	// reference clock with uneven duty
	initial begin
		o_ref = 1'b0;
		#3;
		forever begin
			o_ref = 1'b1;
			#(i_high * 10);
			o_ref = 1'b0;
			#((i_period - i_high) * 10);
		end
	end
	always @(posedge i_mclk) flip_ff <= ~flip_ff;
	// one output wired back; a floating pin shows no stable level
	always_comb begin
		if (i_fb_bank_one) o_fb = i_oe1_n[0] ? flip_ff : i_b1[0];
		else o_fb = i_oe2_n[0] ? flip_ff : i_b2[0];
	end
endmodule : pfr_board

`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
	import pfr_pkg::*;
	localparam logic [31:0] ST_A = 32'(1 << PFR_STAT_LOCK_BIT | 1 << PFR_STAT_RANGE_OK_BIT |
		1 << PFR_STAT_FB_MATCH_BIT | 1 << PFR_STAT_OUT_ON_BIT);
	localparam logic [31:0] ST_B = ST_A | 32'(1 << PFR_STAT_CFG_B_BIT);
	logic        i_mclk, i_arst_n, i_hsel, i_hwrite, i_ratio_select, i_output_enable_n;
	logic        i_loop_bypass_test, i_half_rate_divider_clear, fbone, msel;
	logic [31:0] i_haddr, i_hwdata, r, got;
	logic [1:0]  i_htrans;
	logic [7:0]  period, high;
	wire  logic  [31:0] o_hrdata;
	wire  logic  o_hreadyout, o_hresp, o_lock, i_reference_clock_in, i_loop_feedback_in;
	wire  logic  [2:0] o_bank_one_clock_outputs, o_bank_one_oe_n;
	wire  logic  [2:0] o_bank_two_clock_outputs, o_bank_two_oe_n;
	wire  logic  mbit = msel ? o_bank_one_clock_outputs[0] : o_bank_two_clock_outputs[0];
	int          err_count = 0;
	int          tests_run = 0;
	string       nq[$];
	logic [31:0] eq[$];
	event        ev;

	pfr_top #(.LOCK_PERIODS(4)) dut (.i_mclk, .i_arst_n, .i_hsel, .i_haddr, .i_htrans,
		.i_hwrite, .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hrdata,
		.o_hreadyout, .o_hresp, .i_reference_clock_in, .i_loop_feedback_in, .i_ratio_select,
		.i_output_enable_n, .i_loop_bypass_test, .i_half_rate_divider_clear,
		.o_bank_one_clock_outputs, .o_bank_one_oe_n, .o_bank_two_clock_outputs,
		.o_bank_two_oe_n, .o_lock);
	pfr_board u_board (.i_mclk, .i_period(period), .i_high(high), .i_fb_bank_one(fbone),
		.i_b1(o_bank_one_clock_outputs), .i_oe1_n(o_bank_one_oe_n),
		.i_b2(o_bank_two_clock_outputs), .i_oe2_n(o_bank_two_oe_n),
		.o_ref(i_reference_clock_in), .o_fb(i_loop_feedback_in));
	////////////////////////////////////////////////////////////////
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	initial begin
		#1000000;
		err_count++;
		stop_test();
	end
	// compares each result with the oldest note
	always @(ev) begin
		string       n;
		logic [31:0] e;
		n = nq.pop_front();
		e = eq.pop_front();
		tests_run++;
		if (got !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, got);
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nq.push_back(nm);
		eq.push_back(e);
		got = g;
		->ev;
		#1;
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : cyc
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int c;
		c = 0;
		i_htrans <= 2'h2;
		i_haddr  <= a;
		i_hwrite <= w;
		do begin @(posedge i_mclk); c++; end while (o_hreadyout !== 1'b1 && c < 50);
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		do begin @(posedge i_mclk); c++; end while (o_hreadyout !== 1'b1 && c < 50);
		rd = o_hrdata;
	endtask : bus
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		chk(nm, e, v);
	endtask : rd
	// full period of bank output bit 0, rise to rise
	task automatic per(input logic one, input int e, input string nm);
		int c, n;
		msel = one;
		c = 0;
		n = 0;
		while (mbit !== 1'b0 && c < 600) begin @(posedge i_mclk); c++; end
		while (mbit !== 1'b1 && c < 600) begin @(posedge i_mclk); c++; end
		while (mbit === 1'b1 && c < 600) begin @(posedge i_mclk); c++; n++; end
		while (mbit !== 1'b1 && c < 600) begin @(posedge i_mclk); c++; n++; end
		chk(nm, 32'(e), 32'(n));
	endtask : per
	task automatic wait_lock();
		int c;
		c = 0;
		cyc(4);
		while (o_lock !== 1'b1 && c < 3000) begin @(posedge i_mclk); c++; end
		chk("lock", 32'h1, {31'h0, o_lock});
	endtask : wait_lock
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hf84f05a4));
		i_arst_n = 1'b0;
		i_hsel = 1'b1;
		i_haddr = 32'h0;
		i_htrans = 2'h0;
		i_hwrite = 1'b0;
		i_hwdata = 32'h0;
		i_ratio_select = 1'b0;
		i_output_enable_n = 1'b0;
		i_loop_bypass_test = 1'b0;
		i_half_rate_divider_clear = 1'b0;
		period = 8'd24;
		high = 8'd12;
		fbone = 1'b0;
		msel = 1'b0;
		cyc(6);
		i_arst_n <= 1'b1;
		@(posedge i_mclk);
		chk("lock after reset", 32'h0, {31'h0, o_lock});
		rd(PFR_ADDR_CTRL, PFR_CTRL_RESET, "ctrl reset");
		bus(1'b1, 32'h0000_0010, 32'hffff_ffff, r);
		rd(32'h0000_0010, 32'h0, "unmapped");
		$display("test reset done");
		high <= 8'(3 + $urandom % 18);
		wait_lock();
		per(1'b0, 24, "bank two 1x");
		per(1'b1, 24, "bank one 1x");
		rd(PFR_ADDR_PERIOD, {16'd24, 16'd24}, "periods");
		rd(PFR_ADDR_STATUS, ST_A, "status a");
		i_ratio_select <= 1'b1;
		wait_lock();
		per(1'b1, 48, "bank one half");
		per(1'b0, 24, "bank two a");
		i_half_rate_divider_clear <= 1'b1;
		cyc(3);
		i_half_rate_divider_clear <= 1'b0;
		cyc(3);
		chk("cleared", 32'h0, {29'h0, o_bank_one_clock_outputs});
		$display("test config a done");
		bus(1'b1, PFR_ADDR_CTRL, 32'h1, r);
		fbone <= 1'b1;
		period <= 8'd48;
		high <= 8'(3 + $urandom % 40);
		wait_lock();
		per(1'b1, 48, "bank one b");
		per(1'b0, 24, "bank two 2x");
		rd(PFR_ADDR_STATUS, ST_B, "status b");
		bus(1'b1, PFR_ADDR_CTRL, 32'h3, r);
		cyc(3);
		chk("relock", 32'h0, {31'h0, o_lock});
		rd(PFR_ADDR_CTRL, 32'h1, "ctrl relock clear");
		$display("test config b done");
		i_output_enable_n <= 1'b1;
		cyc(4);
		chk("oe float", 32'h3f, {26'h0, o_bank_one_oe_n, o_bank_two_oe_n});
		chk("quiet", 32'h0, {26'h0, o_bank_one_clock_outputs, o_bank_two_clock_outputs});
		i_output_enable_n <= 1'b0;
		cyc(2);
		chk("oe drive", 32'h0, {26'h0, o_bank_one_oe_n, o_bank_two_oe_n});
		wait_lock();
		$display("test enable done");
		i_loop_bypass_test <= 1'b1;
		cyc(4);
		chk("bypass lock", 32'h0, {31'h0, o_lock});
		per(1'b0, 48, "bypass bank two");
		per(1'b1, 96, "bypass bank one");
		i_loop_bypass_test <= 1'b0;
		wait_lock();
		$display("test bypass done");
		stop_test();
	end
endmodule : tb

`default_nettype wire
